// >>> dmwm_adder.sv
// Remapping adder that aligns an 8-bit page offset onto the CPU address.
`default_nettype none
module dmwm_adder (
    input wire logic [7:0] pageOffset,
    input wire logic gran16k,
    input wire logic [15:0] cpuOffset,
    output logic [20:0] dispAddr
);
    logic [20:0] base;
    always_comb
    begin
        if (gran16k)
        begin
            // The top offset bit falls off the 21-bit address, so 16K pages reach 2 Mbyte.
            base = {pageOffset[6:0], 14'h0};
        end
        else
        begin
            base = {1'b0, pageOffset, 12'h000};
        end
        dispAddr = base + {5'h00, cpuOffset};
    end
endmodule : dmwm_adder
`default_nettype wire

// >>> dmwm_host_model.sv
// Host processor model that issues single memory accesses.
`default_nettype none
module dmwm_host_model (
    input wire logic mclk,
    output logic hostValid,
    output logic [23:0] hostAddr
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        hostValid = 1'b0;
        hostAddr = 24'h000000;
    end
    // A released address bus shows the inverse, so a stale address never matches by luck.
    task access(input logic [23:0] a);
        @(posedge mclk);
        hostValid <= 1'b1;
        hostAddr <= a;
        @(posedge mclk);
        hostValid <= 1'b0;
        hostAddr <= ~a;
    endtask : access
endmodule : dmwm_host_model
`default_nettype wire

// >>> dmwm_mapper.sv
// Host-to-display memory window mapper with indexed extension registers.
`default_nettype none
module dmwm_mapper #(
    parameter int MEM_ADDR_W = 20
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic seqSelect,
    input wire logic [7:0] regIndex,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    input wire logic hostValid,
    input wire logic [23:0] hostAddr,
    input wire logic chainFour,
    input wire logic miscOutPage,
    output logic memHit,
    output logic [20:0] memAddr,
    output logic [1:0] memPlane
);
    logic [7:0] pageOffsetLow_reg;
    logic [7:0] pageOffsetHigh_reg;
    logic [7:0] gfxModeExt_reg;
    logic [7:0] extSeqModes_reg;
    logic [7:0] miscGraphics_reg;
    logic [1:0] chainSync_reg;
    logic [1:0] pageSync_reg;
    logic [7:0] offsetSel;
    logic [20:0] windowAddr;
    logic [3:0] linSeg;
    logic dualPage;
    logic gran16k;
    logic hitNext;
    logic [20:0] addrNext;
    logic [1:0] planeNext;
    logic [20:0] memMask;

    assign linSeg = extSeqModes_reg[dmwm_pkg::LIN_SEG_HI:dmwm_pkg::LIN_SEG_LO];
    assign dualPage = gfxModeExt_reg[dmwm_pkg::BIT_DUAL_PAGE];
    assign gran16k = gfxModeExt_reg[dmwm_pkg::BIT_GRAN_16K];
    assign memMask = 21'((22'h1 << MEM_ADDR_W) - 22'h1);

    // Mode straps from outside the clock domain are synchronised before use.
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            chainSync_reg <= 2'h0;
            pageSync_reg <= 2'h0;
        end
        else
        begin
            chainSync_reg <= {chainSync_reg[0], chainFour};
            pageSync_reg <= {pageSync_reg[0], miscOutPage};
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            pageOffsetLow_reg <= dmwm_pkg::RESET_OFFSET;
            pageOffsetHigh_reg <= dmwm_pkg::RESET_OFFSET;
            gfxModeExt_reg <= dmwm_pkg::RESET_GFX_EXT;
            extSeqModes_reg <= dmwm_pkg::RESET_SEQ;
            miscGraphics_reg <= dmwm_pkg::RESET_MISC_GFX;
        end
        else if (regWrite)
        begin
            if (seqSelect)
            begin
                if (regIndex == dmwm_pkg::IDX_EXT_SEQ_MODES)
                begin
                    extSeqModes_reg <= regWdata;
                end
            end
            else
            begin
                case (regIndex)
                    dmwm_pkg::IDX_PAGE_OFFSET_LOW: pageOffsetLow_reg <= regWdata;
                    dmwm_pkg::IDX_PAGE_OFFSET_HIGH: pageOffsetHigh_reg <= regWdata;
                    dmwm_pkg::IDX_GFX_MODE_EXT: gfxModeExt_reg <= regWdata;
                    dmwm_pkg::IDX_MISC_GRAPHICS: miscGraphics_reg <= regWdata;
                    default: ;
                endcase
            end
        end
    end

    // Reads return stored values so read-modify-write of the mode bit works.
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            regRdata <= 8'h00;
        end
        else if (regRead)
        begin
            if (seqSelect)
            begin
                regRdata <= (regIndex == dmwm_pkg::IDX_EXT_SEQ_MODES) ? extSeqModes_reg : 8'h00;
            end
            else
            begin
                case (regIndex)
                    dmwm_pkg::IDX_PAGE_OFFSET_LOW: regRdata <= pageOffsetLow_reg;
                    dmwm_pkg::IDX_PAGE_OFFSET_HIGH: regRdata <= pageOffsetHigh_reg;
                    dmwm_pkg::IDX_GFX_MODE_EXT: regRdata <= gfxModeExt_reg;
                    dmwm_pkg::IDX_MISC_GRAPHICS: regRdata <= miscGraphics_reg;
                    default: regRdata <= 8'h00;
                endcase
            end
        end
    end

    // Bit 15 chooses the second page only in dual-page mode.
    assign offsetSel = (dualPage && hostAddr[dmwm_pkg::CPU_PAGE_BIT]) ?
        pageOffsetHigh_reg : pageOffsetLow_reg;

    dmwm_adder u_adder (
        .pageOffset(offsetSel),
        .gran16k(gran16k),
        .cpuOffset(hostAddr[15:0]),
        .dispAddr(windowAddr)
    );

    always_comb
    begin
        hitNext = 1'b0;
        addrNext = 21'h000000;
        planeNext = 2'h0;
        if (linSeg != 4'h0)
        begin
            // Linear aperture claims the whole segment even with less memory.
            hitNext = hostAddr[23:20] == linSeg;
            if (chainSync_reg[1])
            begin
                addrNext = {1'b0, hostAddr[19:0]} & memMask;
                planeNext = hostAddr[1:0];
            end
            else
            begin
                // Each plane repeats four times across the segment.
                addrNext = {3'h0, hostAddr[17:0]} & memMask;
                planeNext = 2'h0;
            end
        end
        else if (hostAddr[23:20] == 4'h0)
        begin
            case (miscGraphics_reg[dmwm_pkg::MAP_HI:dmwm_pkg::MAP_LO])
                dmwm_pkg::MAP_A0_128K:
                    hitNext = hostAddr[19:16] == dmwm_pkg::SEG_A0[3:0] ||
                        hostAddr[19:16] == dmwm_pkg::SEG_B0[3:0];
                dmwm_pkg::MAP_A0_64K:
                    hitNext = hostAddr[19:16] == dmwm_pkg::SEG_A0[3:0];
                dmwm_pkg::MAP_B0_32K:
                    hitNext = hostAddr[19:15] == {dmwm_pkg::SEG_B0[3:0], 1'b0};
                dmwm_pkg::MAP_B8_32K:
                    hitNext = hostAddr[19:15] == {dmwm_pkg::SEG_B0[3:0], 1'b1};
                default: hitNext = 1'b0;
            endcase
            hitNext = hitNext && pageSync_reg[1] | hitNext;
            addrNext = windowAddr & (gran16k ? 21'h1fffff : memMask);
            planeNext = 2'h0;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            memHit <= 1'b0;
            memAddr <= 21'h000000;
            memPlane <= 2'h0;
        end
        else
        begin
            memHit <= hostValid && hitNext;
            memAddr <= addrNext;
            memPlane <= planeNext;
        end
    end

    a_offset_readback: assert property (@(posedge mclk) disable iff (srst)
        regWrite && !seqSelect && regIndex == dmwm_pkg::IDX_PAGE_OFFSET_LOW
        ##1 !regWrite
        ##1 regRead && !seqSelect && regIndex == dmwm_pkg::IDX_PAGE_OFFSET_LOW
        |=> regRdata == $past(regWdata, 3))
        else $error("Page offset readback mismatch.");

    a_linear_hit: assert property (@(posedge mclk) disable iff (srst)
        hostValid && linSeg != 4'h0 && hostAddr[23:20] == linSeg |=> memHit)
        else $error("Linear segment access not claimed.");

    a_linear_miss: assert property (@(posedge mclk) disable iff (srst)
        hostValid && linSeg != 4'h0 && hostAddr[23:20] != linSeg |=> !memHit)
        else $error("Access outside the linear segment was claimed.");

    a_planar_repeat: assert property (@(posedge mclk) disable iff (srst)
        hostValid && linSeg != 4'h0 && !chainSync_reg[1]
        |=> memAddr[20:18] == 3'h0 && memPlane == 2'h0)
        else $error("Planar linear address exceeds one plane.");

    a_single_page_addr: assert property (@(posedge mclk) disable iff (srst)
        hostValid && linSeg == 4'h0 && hostAddr[23:16] == 8'h0a && !dualPage && !gran16k
        |=> memAddr == 21'(($past(pageOffsetLow_reg) * 21'h1000 +
            $past(hostAddr[15:0])) & memMask))
        else $error("Single-page address wrong.");

    a_dual_high_page: assert property (@(posedge mclk) disable iff (srst)
        hostValid && linSeg == 4'h0 && hostAddr[23:20] == 4'h0 && dualPage && hostAddr[15]
        && !gran16k
        |=> memAddr[19:12] == 8'($past(pageOffsetHigh_reg) + 8'($past(hostAddr[15:12]))))
        else $error("Dual-page high offset not used.");
endmodule : dmwm_mapper
`default_nettype wire

// >>> dmwm_pkg.sv
// Package with register indices, field positions, reset values and address constants.
`default_nettype none
package dmwm_pkg;
    localparam logic [7:0] IDX_PAGE_OFFSET_LOW = 8'h09;
    localparam logic [7:0] IDX_PAGE_OFFSET_HIGH = 8'h0a;
    localparam logic [7:0] IDX_GFX_MODE_EXT = 8'h0b;
    localparam logic [7:0] IDX_EXT_SEQ_MODES = 8'h07;
    localparam logic [7:0] IDX_MISC_GRAPHICS = 8'h06;
    localparam int BIT_DUAL_PAGE = 0;
    localparam int BIT_GRAN_16K = 5;
    localparam int LIN_SEG_HI = 7;
    localparam int LIN_SEG_LO = 4;
    localparam int MAP_HI = 3;
    localparam int MAP_LO = 2;
    localparam int CPU_PAGE_BIT = 15;
    localparam logic [7:0] RESET_OFFSET = 8'h00;
    localparam logic [7:0] RESET_GFX_EXT = 8'h00;
    localparam logic [7:0] RESET_SEQ = 8'h00;
    localparam logic [7:0] RESET_MISC_GFX = 8'h04;
    localparam logic [1:0] MAP_A0_128K = 2'h0;
    localparam logic [1:0] MAP_A0_64K = 2'h1;
    localparam logic [1:0] MAP_B0_32K = 2'h2;
    localparam logic [1:0] MAP_B8_32K = 2'h3;
    localparam logic [7:0] SEG_A0 = 8'h0a;
    localparam logic [7:0] SEG_B0 = 8'h0b;
    localparam logic [3:0] PLANE_A8 = 4'h8;
    localparam logic [3:0] PLANE_B8 = 4'hb;
    localparam int ADDR_W = 24;
    localparam int DISP_W = 21;
endpackage : dmwm_pkg
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench for the display memory window mapper.
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] LO = dmwm_pkg::IDX_PAGE_OFFSET_LOW;
    localparam logic [7:0] HI = dmwm_pkg::IDX_PAGE_OFFSET_HIGH;
    localparam logic [7:0] GX = dmwm_pkg::IDX_GFX_MODE_EXT;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic seqSelect = 1'b0;
    logic [7:0] regIndex = 8'h00;
    logic [7:0] regWdata = 8'h00;
    logic [7:0] regRdata;
    logic hostValid;
    logic [23:0] hostAddr;
    logic chainFour = 1'b0;
    logic miscOutPage = 1'b0;
    logic memHit;
    logic [20:0] memAddr;
    logic [1:0] memPlane;
    logic [7:0] rv;
    int errCount = 0;
    int checksDone = 0;
    always #2.5 mclk = ~mclk;
    dmwm_mapper dmwm_mapper_i (.mclk(mclk), .srst(srst), .regWrite(regWrite),
        .regRead(regRead), .seqSelect(seqSelect), .regIndex(regIndex), .regWdata(regWdata),
        .regRdata(regRdata), .hostValid(hostValid), .hostAddr(hostAddr),
        .chainFour(chainFour), .miscOutPage(miscOutPage), .memHit(memHit),
        .memAddr(memAddr), .memPlane(memPlane));
    dmwm_host_model dmwm_host_model_i (.mclk(mclk), .hostValid(hostValid),
        .hostAddr(hostAddr));
    task testDone;
        $display("checks %0d mismatches %0d", checksDone, errCount);
        if (errCount == 0 && checksDone > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : testDone
    task tally(input logic [20:0] g, input logic [20:0] e);
        checksDone++;
        if (g !== e)
        begin
            errCount++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : tally
    task chkReg(input logic [7:0] g, input logic [7:0] e);
        tally({13'h0000, g}, {13'h0000, e});
    endtask : chkReg
    task chkHit(input logic g, input logic e);
        tally({20'h00000, g}, {20'h00000, e});
    endtask : chkHit
    task chkAddr(input logic [20:0] g, input logic [20:0] e);
        tally(g, e);
    endtask : chkAddr
    task chkPlane(input logic [1:0] g, input logic [1:0] e);
        tally({19'h00000, g}, {19'h00000, e});
    endtask : chkPlane
    task wr(input logic s, input logic [7:0] i, input logic [7:0] d);
        @(posedge mclk);
        regWrite <= 1'b1;
        seqSelect <= s;
        regIndex <= i;
        regWdata <= d;
        @(posedge mclk);
        regWrite <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] i);
        @(posedge mclk);
        regRead <= 1'b1;
        seqSelect <= 1'b0;
        regIndex <= i;
        @(posedge mclk);
        regRead <= 1'b0;
        #1 rv = regRdata;
    endtask : rd
    // Window address: offset on a 4K boundary plus the low 16 CPU address bits.
    function automatic logic [20:0] pg(input logic [7:0] o, input logic [23:0] a);
        return {1'b0, o, 12'h000} + {5'h00, a[15:0]};
    endfunction : pg
    task acc(input logic [23:0] a, input logic h, input logic [20:0] e);
        dmwm_host_model_i.access(a);
        #1;
        chkHit(memHit, h);
        if (h)
            chkAddr(memAddr, e);
    endtask : acc
    initial
    begin
        #20000;
        errCount++;
        testDone();
    end
    initial
    begin
        repeat (16) @(posedge mclk);
        srst <= 1'b0;
        rd(LO);
        chkReg(rv, 8'h00);
        wr(1'b0, LO, 8'hff);
        wr(1'b0, HI, 8'h80);
        rd(LO);
        chkReg(rv, 8'hff);
        rd(HI);
        chkReg(rv, 8'h80);
        acc(24'h0a0000, 1'b1, pg(8'hff, 24'h0a0000));
        acc(24'h0b0000, 1'b0, 21'h000000);
        wr(1'b0, LO, 8'h12);
        rd(LO);
        chkReg(rv, 8'h12);
        acc(24'h0a1234, 1'b1, pg(8'h12, 24'h0a1234));
        rd(GX);
        wr(1'b0, GX, rv | 8'h01);
        rd(GX);
        chkReg(rv, 8'h01);
        acc(24'h0a1234, 1'b1, pg(8'h12, 24'h0a1234));
        acc(24'h0a9234, 1'b1, pg(8'h80, 24'h0a9234));
        rd(GX);
        wr(1'b0, GX, rv & 8'hfe);
        acc(24'h0a9234, 1'b1, pg(8'h12, 24'h0a9234));
        wr(1'b0, GX, 8'h20);
        wr(1'b0, LO, 8'h40);
        acc(24'h0a1234, 1'b1, 21'h101234);
        wr(1'b0, dmwm_pkg::IDX_MISC_GRAPHICS, 8'h08);
        acc(24'h0a0000, 1'b0, 21'h000000);
        acc(24'h0b0000, 1'b1, 21'h100000);
        @(posedge mclk);
        chainFour <= 1'b1;
        miscOutPage <= 1'b1;
        wr(1'b1, dmwm_pkg::IDX_EXT_SEQ_MODES, 8'h30);
        acc(24'h312345, 1'b1, 21'h012345);
        chkPlane(memPlane, 2'h1);
        acc(24'h0b0000, 1'b0, 21'h000000);
        acc(24'h2fffff, 1'b0, 21'h000000);
        @(posedge mclk);
        chainFour <= 1'b0;
        repeat (3) @(posedge mclk);
        acc(24'h3e2345, 1'b1, 21'h022345);
        chkPlane(memPlane, 2'h0);
        acc(24'h3a2345, 1'b1, 21'h022345);
        // A second reset in mid-run must bring back the standard window settings.
        @(posedge mclk);
        srst <= 1'b1;
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        rd(LO);
        chkReg(rv, dmwm_pkg::RESET_OFFSET);
        rd(GX);
        chkReg(rv, dmwm_pkg::RESET_GFX_EXT);
        acc(24'h0a1234, 1'b1, 21'h001234);
        testDone();
    end
endmodule : tb_top
`default_nettype wire
